/* hdl/fmt_defs.svh */
// offsets, field positions, reset values and counts of the formatter
`ifndef FMT_DEFS_SVH
`define FMT_DEFS_SVH
`define IDX_TRAINING 8'h4e
`define IDX_CHAN_DIS 8'h50
`define IDX_PIN1_SEL 8'h6c
`define IDX_PIN2_SEL 8'h6d
`define IDX_CONFIG 8'h70
`define IDX_ROWS 8'h71
`define IDX_STATUS 8'h72
`define RST_TRAINING 12'h3a6
`define RST_CHAN_DIS 24'h000000
`define RST_PIN_SEL 8'h00
`define RST_CONFIG 3'h0
`define RST_ROWS 12'h800
`define CFG_WL12_BIT 2
`define BURST_LAST 7'h7f
`define WL10_LAST 4'h9
`define WL12_LAST 4'hb
`define MASK10 12'h3ff
`define MASK12 12'hfff
`define CW_FIXED_HI 4'h2
`define CW_IDLE 12'h200
`define SEL_INTEG1 8'h00
`define SEL_INTEG2 8'h01
`define SEL_PIXVALID 8'h02
`define SEL_ROWVALID 8'h03
`define SEL_FRAMEVALID 8'h04
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* hdl/fmt_pkg.sv */
// types shared by the output formatter modules
package fmt_pkg;
	// sequencer states, gray along idle-row-burst-slot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ROWOH = 2'b01,
		ST_BURST = 2'b11,
		ST_SLOTOH = 2'b10
	} seq_state_t;
	// number of active data outputs
	typedef enum logic [1:0] {
		MODE16 = 2'b00,
		MODE8 = 2'b01,
		MODE4 = 2'b10,
		MODE2 = 2'b11
	} chan_mode_t;
endpackage

/* hdl/word_if.sv */
// word handed from the formatter to one serial lane
`timescale 1ns/1ps
`default_nettype none
interface word_if;
	logic [11:0] word;
	logic load;
	modport src (output word, output load);
	modport snk (input word, input load);
endinterface
`default_nettype wire

/* hdl/ser_lane.sv */
// shift register sending one word per pixel, least significant bit first
`timescale 1ns/1ps
`default_nettype none
module ser_lane (
	input wire logic clk,
	input wire logic rst,
	word_if.snk wi,
	output logic bitOut
);
	logic [11:0] shift_r;

	// load on the pixel enable, else shift down one bit per clock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			shift_r <= 12'h000;
		else if (wi.load)
			shift_r <= wi.word;
		else
			shift_r <= {1'b0, shift_r[11:1]};
	end
	assign bitOut = shift_r[0];

	property p_lsb_first;
		@(posedge clk) disable iff (rst)
		wi.load |=> bitOut == $past(wi.word[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first)
		else $error("lane did not start with bit 0");
	property p_shift_on;
		@(posedge clk) disable iff (rst)
		!wi.load |=> bitOut == $past(shift_r[1]);
	endproperty
	a_shift_on: assert property (p_shift_on)
		else $error("lane skipped a bit");
endmodule
`default_nettype wire

/* hdl/sync_pin.sv */
// three-stage synchroniser for a pin from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_pin (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level_r <= s3_r;
		end
	end
	assign level = level_r;
endmodule
`default_nettype wire

/* hdl/output_formatter.sv */
// sensor output formatter: sequencer, lane mapping, control word, registers
`timescale 1ns/1ps
`default_nettype none
`include "fmt_defs.svh"
module output_formatter (
	input wire logic clk,
	input wire logic rst,
	input wire logic frameReqPin,
	input wire logic inteBlk1,
	input wire logic inteBlk2,
	input wire logic fotActive,
	input wire logic [11:0] pixelIn [16],
	output logic pixelTake,
	output logic [15:0] dataLane,
	output logic ctrlLane,
	output logic serialOutputClock,
	output logic testPinOne,
	output logic testPinTwo,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	fmt_pkg::seq_state_t state_r;
	fmt_pkg::seq_state_t stNxt;
	fmt_pkg::chan_mode_t modeAct_r;
	fmt_pkg::chan_mode_t modeEff;
	logic [11:0] trainWord_r;
	logic [23:0] chanDis_r;
	logic [7:0] pin1Sel_r;
	logic [7:0] pin2Sel_r;
	logic [2:0] cfg_r;
	logic [11:0] rows_r;
	logic wl12Act_r;
	logic [3:0] wlCnt_r;
	logic [6:0] pixCnt_r;
	logic [6:0] pixNxt;
	logic [2:0] burstCnt_r;
	logic [2:0] burstNxt;
	logic [11:0] rowCnt_r;
	logic [11:0] rowNxt;
	logic [11:0] ctrlWord_r;
	logic [11:0] laneWord_r [16];
	logic [11:0] laneNext [16];
	logic serial_output_clock_r;
	logic take_r;
	logic pin1_r;
	logic pin2_r;
	logic reqPend_r;
	logic reqLevel;
	logic reqPrev_r;

	// byte-lane merge of a bus write into a register
	function automatic logic [31:0] strbMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				m[8*b +: 8] = nw[8*b +: 8];
		return m;
	endfunction

	// lane whose data an output repeats in a reduced mode
	function automatic logic [3:0] srcLane(input logic [3:0] idx,
		input fmt_pkg::chan_mode_t m);
		return idx & ~((4'h1 << m) - 4'h1);
	endfunction

	// control word bit shown on a test pin
	function automatic logic pickStatus(input logic [7:0] sel,
		input logic [11:0] cw);
		case (sel)
			`SEL_INTEG1: return cw[6];
			`SEL_INTEG2: return cw[7];
			`SEL_PIXVALID: return cw[0];
			`SEL_ROWVALID: return cw[1];
			`SEL_FRAMEVALID: return cw[2];
			default: return 1'b0;
		endcase
	endfunction

	// frame request pin crossing and edge capture
	sync_pin uReq (
		.clk(clk),
		.rst(rst),
		.pin(frameReqPin),
		.level(reqLevel)
	);

	// pixel enable divider: one pixel per word length of clocks
	wire wl12Cfg = cfg_r[`CFG_WL12_BIT];
	wire [3:0] wlLast = wl12Act_r ? `WL12_LAST : `WL10_LAST;
	wire pixEn = (wlCnt_r == wlLast);
	wire [3:0] wlCntNxt = pixEn ? 4'h0 : wlCnt_r + 4'h1;
	wire idle = (state_r == fmt_pkg::ST_IDLE);
	wire reqEdge = reqLevel & ~reqPrev_r & idle;
	wire startNow = pixEn & idle & reqPend_r;

	// 12-bit conversion caps the output count at four
	wire [1:0] modeCfg = cfg_r[1:0];
	assign modeEff = (wl12Cfg && modeCfg < 2'b10) ?
		fmt_pkg::MODE4 : fmt_pkg::chan_mode_t'(modeCfg);

	// burst and row bookkeeping, bursts per row follow the mode
	wire [2:0] burstLast = 3'((4'h1 << modeAct_r) - 4'h1);
	wire lastBurst = (burstCnt_r == burstLast);
	wire lastRow = (rowCnt_r == rows_r - 12'h001);
	wire burstEnd = (pixCnt_r == `BURST_LAST);

	// sequencer next state, evaluated once per pixel
	always_comb
	begin
		stNxt = state_r;
		pixNxt = pixCnt_r;
		burstNxt = burstCnt_r;
		rowNxt = rowCnt_r;
		case (state_r)
			fmt_pkg::ST_IDLE:
				if (reqPend_r)
				begin
					stNxt = fmt_pkg::ST_ROWOH;
					rowNxt = 12'h000;
					burstNxt = 3'h0;
				end
			fmt_pkg::ST_ROWOH, fmt_pkg::ST_SLOTOH:
			begin
				stNxt = fmt_pkg::ST_BURST;
				pixNxt = 7'h00;
			end
			fmt_pkg::ST_BURST:
				if (!burstEnd)
					pixNxt = pixCnt_r + 7'h01;
				else if (!lastBurst)
				begin
					stNxt = fmt_pkg::ST_SLOTOH;
					burstNxt = burstCnt_r + 3'h1;
				end
				else if (lastRow)
					stNxt = fmt_pkg::ST_IDLE;
				else
				begin
					stNxt = fmt_pkg::ST_ROWOH;
					burstNxt = 3'h0;
					rowNxt = rowCnt_r + 12'h001;
				end
			default: stNxt = fmt_pkg::ST_IDLE;
		endcase
	end

	// control word of the current pixel slot
	wire pixValidN = (state_r == fmt_pkg::ST_BURST);
	wire rowValidN = pixValidN | (state_r == fmt_pkg::ST_SLOTOH);
	wire frameValidN = ~idle;
	wire rowOhN = (state_r == fmt_pkg::ST_ROWOH);
	wire slotOhN = rowOhN | (state_r == fmt_pkg::ST_SLOTOH);
	wire integ1N = inteBlk1 & ~fotActive;
	wire integ2N = inteBlk2 & ~fotActive;
	wire [11:0] ctrlNext = {`CW_FIXED_HI, integ2N, integ1N, fotActive,
		rowOhN, slotOhN, frameValidN, rowValidN, pixValidN};
	wire [11:0] wlMask = wl12Act_r ? `MASK12 : `MASK10;
	wire [11:0] trainMasked = trainWord_r & wlMask;

	// per-lane data: pixel, training word or powered-down zero
	for (genvar i = 0; i < 16; i++)
	begin : gLane
		word_if lw ();
		wire [3:0] src = srcLane(4'(i), modeAct_r);
		assign laneNext[i] = chanDis_r[i] ? 12'h000 :
			(pixValidN ? pixelIn[src] : trainWord_r) & wlMask;
		assign lw.word = laneWord_r[i];
		assign lw.load = pixEn;
		ser_lane uSer (
			.clk(clk),
			.rst(rst),
			.wi(lw),
			.bitOut(dataLane[i])
		);
	end

	// control lane carries status only, never training
	word_if cw ();
	assign cw.word = ctrlWord_r;
	assign cw.load = pixEn;
	ser_lane uCtrl (
		.clk(clk),
		.rst(rst),
		.wi(cw),
		.bitOut(ctrlLane)
	);

	// divider, frame request and sequencer registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wlCnt_r <= 4'h0;
			serial_output_clock_r <= 1'b1;
			reqPrev_r <= 1'b0;
			reqPend_r <= 1'b0;
			state_r <= fmt_pkg::ST_IDLE;
			pixCnt_r <= 7'h00;
			burstCnt_r <= 3'h0;
			rowCnt_r <= 12'h000;
			modeAct_r <= fmt_pkg::MODE16;
			wl12Act_r <= 1'b0;
		end
		else
		begin
			wlCnt_r <= wlCntNxt;
			serial_output_clock_r <= ~wlCntNxt[0];
			reqPrev_r <= reqLevel;
			reqPend_r <= reqEdge | (reqPend_r & ~startNow);
			if (pixEn)
			begin
				state_r <= stNxt;
				pixCnt_r <= pixNxt;
				burstCnt_r <= burstNxt;
				rowCnt_r <= rowNxt;
			end
			if (pixEn && idle)
			begin
				modeAct_r <= modeEff;
				wl12Act_r <= wl12Cfg;
			end
		end
	end

	// words loaded into the lanes and test pins, once per pixel
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrlWord_r <= `CW_IDLE;
			laneWord_r <= '{default: 12'h000};
			take_r <= 1'b0;
			pin1_r <= 1'b0;
			pin2_r <= 1'b0;
		end
		else
		begin
			take_r <= pixEn & pixValidN;
			if (pixEn)
			begin
				ctrlWord_r <= ctrlNext;
				laneWord_r <= laneNext;
				pin1_r <= pickStatus(pin1Sel_r, ctrlNext);
				pin2_r <= pickStatus(pin2Sel_r, ctrlNext);
			end
		end
	end
	assign pixelTake = take_r;
	assign serialOutputClock = serial_output_clock_r;
	assign testPinOne = pin1_r;
	assign testPinTwo = pin2_r;

	// bus slave: address and data taken in either order
	logic awHeld_r;
	logic wHeld_r;
	logic [11:0] wAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire awTake = awvalid & awready_r;
	wire wTake = wvalid & wready_r;
	wire doWrite = awHeld_r & wHeld_r & ~bvalid_r;
	wire bvalidN = doWrite | (bvalid_r & ~bready);
	wire awHeldN = (awHeld_r | awTake) & ~doWrite;
	wire wHeldN = (wHeld_r | wTake) & ~doWrite;
	wire arTake = arvalid & arready_r;
	wire rvalidN = arTake | (rvalid_r & ~rready);
	wire [7:0] wIdx = wAddr_r[9:2];
	wire wHi = (wAddr_r[11:10] == 2'b00);
	wire [31:0] wOld;
	wire [31:0] wNew = strbMerge(wOld, wData_r, wStrb_r);
	wire wMapped = wHi & (wIdx == `IDX_TRAINING || wIdx == `IDX_CHAN_DIS ||
		wIdx == `IDX_PIN1_SEL || wIdx == `IDX_PIN2_SEL ||
		wIdx == `IDX_CONFIG || wIdx == `IDX_ROWS);
	assign wOld = (wIdx == `IDX_TRAINING) ? {20'h0, trainWord_r} :
		(wIdx == `IDX_CHAN_DIS) ? {8'h0, chanDis_r} :
		(wIdx == `IDX_PIN1_SEL) ? {24'h0, pin1Sel_r} :
		(wIdx == `IDX_PIN2_SEL) ? {24'h0, pin2Sel_r} :
		(wIdx == `IDX_CONFIG) ? {29'h0, cfg_r} : {20'h0, rows_r};
	wire [7:0] rIdx = araddr[9:2];
	wire rHi = (araddr[11:10] == 2'b00);
	wire [31:0] statusWord = {15'h0, wl12Act_r, modeAct_r, rowCnt_r,
		state_r};
	wire rMapped = rHi & (rIdx == `IDX_TRAINING || rIdx == `IDX_CHAN_DIS ||
		rIdx == `IDX_PIN1_SEL || rIdx == `IDX_PIN2_SEL ||
		rIdx == `IDX_CONFIG || rIdx == `IDX_ROWS || rIdx == `IDX_STATUS);
	wire [31:0] rMux = !rMapped ? 32'h0 :
		(rIdx == `IDX_TRAINING) ? {20'h0, trainWord_r} :
		(rIdx == `IDX_CHAN_DIS) ? {8'h0, chanDis_r} :
		(rIdx == `IDX_PIN1_SEL) ? {24'h0, pin1Sel_r} :
		(rIdx == `IDX_PIN2_SEL) ? {24'h0, pin2Sel_r} :
		(rIdx == `IDX_CONFIG) ? {29'h0, cfg_r} :
		(rIdx == `IDX_ROWS) ? {20'h0, rows_r} : statusWord;

	// bus handshake registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			wAddr_r <= 12'h000;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RESP_OKAY;
		end
		else
		begin
			awHeld_r <= awHeldN;
			wHeld_r <= wHeldN;
			if (awTake)
				wAddr_r <= awaddr;
			if (wTake)
			begin
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			awready_r <= ~awHeldN & ~bvalidN;
			wready_r <= ~wHeldN & ~bvalidN;
			bvalid_r <= bvalidN;
			if (doWrite)
				bresp_r <= wMapped ? `RESP_OKAY : `RESP_SLVERR;
			arready_r <= ~rvalidN;
			rvalid_r <= rvalidN;
			if (arTake)
			begin
				rdata_r <= rMux;
				rresp_r <= rMapped ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// software registers steering the formatter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			trainWord_r <= `RST_TRAINING;
			chanDis_r <= `RST_CHAN_DIS;
			pin1Sel_r <= `RST_PIN_SEL;
			pin2Sel_r <= `RST_PIN_SEL;
			cfg_r <= `RST_CONFIG;
			rows_r <= `RST_ROWS;
		end
		else if (doWrite && wHi)
		begin
			if (wIdx == `IDX_TRAINING)
				trainWord_r <= wNew[11:0];
			if (wIdx == `IDX_CHAN_DIS)
				chanDis_r <= wNew[23:0];
			if (wIdx == `IDX_PIN1_SEL)
				pin1Sel_r <= wNew[7:0];
			if (wIdx == `IDX_PIN2_SEL)
				pin2Sel_r <= wNew[7:0];
			if (wIdx == `IDX_CONFIG)
				cfg_r <= wNew[2:0];
			if (wIdx == `IDX_ROWS)
				rows_r <= wNew[11:0];
		end
	end
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// checks on the sequencer and the words it produces
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_burstDone;
		pixEn && state_r == fmt_pkg::ST_BURST && burstEnd;
	endsequence
	property p_fixedBits;
		ctrlWord_r[11:8] == 4'h2;
	endproperty
	a_fixedBits: assert property (p_fixedBits)
		else $error("control word fixed bits wrong");
	property p_inteMask;
		ctrlWord_r[5] |-> ctrlWord_r[7:6] == 2'b00;
	endproperty
	a_inteMask: assert property (p_inteMask)
		else $error("integration bit high in overhead sampling");
	property p_nextSlot;
		s_burstDone ##0 !lastBurst |=> state_r == fmt_pkg::ST_SLOTOH;
	endproperty
	a_nextSlot: assert property (p_nextSlot)
		else $error("row ended before its last burst");
	property p_gap;
		pixEn && state_r == fmt_pkg::ST_SLOTOH |=>
			state_r == fmt_pkg::ST_BURST && pixCnt_r == 7'h00;
	endproperty
	a_gap: assert property (p_gap)
		else $error("overhead gap not one pixel");
	property p_frameEnd;
		s_burstDone ##0 lastBurst && lastRow |=> idle;
	endproperty
	a_frameEnd: assert property (p_frameEnd)
		else $error("frame did not end after last row");
	property p_training;
		pixEn && !pixValidN && !chanDis_r[0] |=>
			laneWord_r[0] == $past(trainMasked);
	endproperty
	a_training: assert property (p_training)
		else $error("training word missing outside valid data");
	property p_dup4;
		pixEn && modeAct_r == fmt_pkg::MODE4 &&
			chanDis_r[7:4] == 4'h0 |=>
			laneWord_r[5] == laneWord_r[4] &&
			laneWord_r[6] == laneWord_r[4] &&
			laneWord_r[7] == laneWord_r[4];
	endproperty
	a_dup4: assert property (p_dup4)
		else $error("inactive lane differs from its neighbour");
	property p_mode12;
		wl12Act_r |-> modeAct_r == fmt_pkg::MODE4 || modeAct_r == fmt_pkg::MODE2;
	endproperty
	a_mode12: assert property (p_mode12)
		else $error("12-bit mode with more than four outputs");
	property p_testPin;
		pixEn && pin1Sel_r == `SEL_PIXVALID |=> pin1_r == ctrlWord_r[0];
	endproperty
	a_testPin: assert property (p_testPin)
		else $error("test pin does not follow pixel valid");
	property p_width10;
		pixEn && !wl12Act_r |=> laneWord_r[3][11:10] == 2'b00;
	endproperty
	a_width10: assert property (p_width10)
		else $error("10-bit word carries upper bits");
endmodule
`default_nettype wire

/* dv/lvds_rx_model.sv */
// receiver model: word alignment on the idle control word, word counting
`timescale 1ns/1ps
`default_nettype none
module lvds_rx_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] dataLane,
	input wire logic ctrlLane,
	input wire logic serialOutputClock,
	input wire logic wl12,
	output logic locked,
	output logic strobe,
	output logic [11:0] ctrlWord,
	output logic [11:0] dataWord [16],
	output int bitCnt [5],
	output int rowEnds,
	output int frameEnds,
	output logic clkErr
);
	logic [11:0] sr [17];
	logic [3:0] ph;
	logic wlSeen;
	logic [11:0] cw;
	logic hit;
	// completed control word before this edge's bit; idle word marks a boundary
	assign cw = wl12 ? sr[16] : {2'h0, sr[16][11:2]};
	assign hit = cw == 12'h200;
	// shift in all lanes lsb first; hand out words at each boundary
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			locked <= 1'b0;
			strobe <= 1'b0;
			clkErr <= 1'b0;
			ctrlWord <= 12'h000;
			ph <= 4'h0;
			wlSeen <= 1'b0;
			rowEnds <= 0;
			frameEnds <= 0;
			for (int b = 0; b < 5; b++)
				bitCnt[b] <= 0;
		end
		else
		begin
			for (int i = 0; i < 16; i++)
				sr[i] <= {dataLane[i], sr[i][11:1]};
			sr[16] <= {ctrlLane, sr[16][11:1]};
			wlSeen <= wl12;
			strobe <= 1'b0;
			if (wl12 != wlSeen)
				locked <= 1'b0;
			else if (!locked ? hit : ph == 4'h0)
			begin
				locked <= locked ? cw[9] : 1'b1; // drop a false lock
				ph <= 4'h1;
				strobe <= locked;
				ctrlWord <= cw;
				for (int i = 0; i < 16; i++)
					dataWord[i] <= wl12 ? sr[i] : {2'h0, sr[i][11:2]};
				if (!serialOutputClock)
					clkErr <= 1'b1;
				// pixels taken only with the valid flag, rows and frames on bits 1-2
				for (int b = 0; b < 5; b++)
					if (locked && cw[b])
						bitCnt[b] <= bitCnt[b] + 1;
				if (locked && ctrlWord[1] && !cw[1])
					rowEnds <= rowEnds + 1;
				if (locked && ctrlWord[2] && !cw[2])
					frameEnds <= frameEnds + 1;
			end
			else
				ph <= (ph == (wl12 ? 4'hb : 4'h9)) ? 4'h0 : ph + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* dv/output_formatter_tb.sv */
// testbench of the output formatter: register bus, lanes, control word
`timescale 1ns/1ps
`default_nettype none
`include "fmt_defs.svh"
module output_formatter_tb;
	logic clk, rst, frameReqPin, inteBlk1, inteBlk2, fotActive;
	logic [11:0] pixelIn [16];
	logic [15:0] dataLane;
	logic ctrlLane, serialOutputClock, testPinOne, testPinTwo, pixelTake;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic locked, strobe, clkErr, wl12, monOn;
	logic [11:0] ctrlWord, trainVal, idleExp;
	logic [11:0] dataWord [16];
	logic [15:0] disMask;
	int bitCnt [5];
	int rowEnds, frameEnds, step, errorCnt, nTests, takeCnt;
	output_formatter output_formatter_i (.clk, .rst, .frameReqPin, .inteBlk1,
		.inteBlk2, .fotActive, .pixelIn, .pixelTake, .dataLane, .ctrlLane,
		.serialOutputClock, .testPinOne, .testPinTwo, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	lvds_rx_model lvds_rx_model_i (.clk, .rst, .dataLane, .ctrlLane,
		.serialOutputClock, .wl12, .locked, .strobe, .ctrlWord, .dataWord,
		.bitCnt, .rowEnds, .frameEnds, .clkErr);
	// status word expected outside a frame
	assign idleExp = 12'h200 | {4'h0, inteBlk2 & ~fotActive,
		inteBlk1 & ~fotActive, fotActive, 5'h00};
	// pixels the formatter reports as taken
	always @(posedge clk)
		if (rst)
			takeCnt <= 0;
		else if (pixelTake === 1'b1)
			takeCnt <= takeCnt + 1;
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic testDone();
		$display("checks %0d errors %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		nTests++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one clock of a bounded wait
	task automatic tick(inout int n, input int lim);
		@(posedge clk);
		n++;
		if (n > lim)
		begin
			errorCnt++;
			$display("ERROR %0t: wait timed out", $time);
			testDone();
		end
	endtask
	task automatic axiWr(input logic [7:0] idx, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic a, w;
		@(posedge clk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a = 1'b0;
		w = 1'b0;
		n = 0;
		while (!(a && w))
		begin
			tick(n, 100);
			if (!a && awready === 1'b1)
			begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		n = 0;
		do tick(n, 100); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er), "write response");
	endtask
	task automatic axiRd(input logic [7:0] idx, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do tick(n, 100); while (arready !== 1'b1);
		arvalid <= 1'b0;
		n = 0;
		do tick(n, 100); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed, "read data");
		chk(32'(rresp), 32'(er), "read response");
	endtask
	// lane word expected for the current control word
	function automatic logic [11:0] laneExp(input int i);
		logic [11:0] m;
		m = wl12 ? 12'hfff : 12'h3ff;
		if (disMask[i])
			return 12'h000;
		return (ctrlWord[0] ? pixelIn[i & ~(step - 1)] : trainVal) & m;
	endfunction
	// compare every received word once settled
	always @(negedge clk)
	begin
		if (monOn && strobe === 1'b1)
		begin
			chk(32'(ctrlWord[11:8]), 32'h2, "fixed bits");
			if (!ctrlWord[2])
				chk(32'(ctrlWord & 12'hfe7), 32'(idleExp), "status");
			for (int i = 0; i < 16; i++)
				chk(32'(dataWord[i]), 32'(laneExp(i)), "lane");
		end
	end
	task automatic waitLock();
		int n;
		monOn = 1'b0;
		repeat (80) @(posedge clk);
		n = 0;
		while (locked !== 1'b1)
			tick(n, 500);
		repeat (40) @(posedge clk);
		monOn = 1'b1;
	endtask
	task automatic setIn(input logic f, input logic i1, input logic i2);
		monOn = 1'b0;
		@(posedge clk);
		fotActive <= f;
		inteBlk1 <= i1;
		inteBlk2 <= i2;
		repeat (40) @(posedge clk);
		monOn = 1'b1;
		repeat (40) @(posedge clk);
		chk(32'(testPinOne), 32'(i1 & ~f), "pin one");
		chk(32'(testPinTwo), 32'(i2 & ~f), "pin two");
	endtask
	task automatic pulse();
		@(posedge clk);
		frameReqPin <= 1'b1;
		repeat (8) @(posedge clk);
		frameReqPin <= 1'b0;
	endtask
	task automatic runFrame(input fmt_pkg::chan_mode_t md, input logic w,
		input int r, input logic [23:0] dm, input logic [7:0] s2);
		int n, re, fe, tk;
		int base [5];
		monOn = 1'b0;
		axiWr(`IDX_CONFIG, {29'h0, w, md}, `RESP_OKAY);
		axiWr(`IDX_ROWS, 32'(r), `RESP_OKAY);
		axiWr(`IDX_CHAN_DIS, {8'h00, dm}, `RESP_OKAY);
		axiWr(`IDX_PIN2_SEL, {24'h0, s2}, `RESP_OKAY);
		step = (w && md < 2) ? 4 : 1 << md;
		wl12 = w;
		disMask = dm[15:0];
		waitLock();
		base = bitCnt;
		re = rowEnds;
		fe = frameEnds;
		tk = takeCnt;
		pulse();
		n = 0;
		while (bitCnt[0] < base[0] + 64)
			tick(n, 5000);
		chk(32'(testPinOne), 32'h1, "pin one in burst");
		chk(32'(testPinTwo), 32'h1, "pin two in burst");
		pulse();
		n = 0;
		while (frameEnds == fe)
			tick(n, 40000);
		repeat (60) @(posedge clk);
		chk(32'(bitCnt[0] - base[0]), 32'(r * 128 * step), "valid");
		chk(32'(bitCnt[1] - base[1]), 32'(r * (129 * step - 1)), "row");
		chk(32'(bitCnt[3] - base[3]), 32'(r * step), "slot oh");
		chk(32'(bitCnt[4] - base[4]), 32'(r), "row oh");
		chk(32'(rowEnds - re), 32'(r), "rows");
		chk(32'(frameEnds - fe), 32'h1, "frames");
		chk(32'(takeCnt - tk), 32'(r * 128 * step), "taken");
	endtask
	initial
	begin
		rst = 1'b1;
		{frameReqPin, inteBlk1, inteBlk2, fotActive} = 4'h0;
		{awvalid, wvalid, bready, arvalid, rready, monOn, wl12} = 7'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		wstrb = 4'hf;
		errorCnt = 0;
		nTests = 0;
		step = 1;
		disMask = 16'h0000;
		trainVal = `RST_TRAINING;
		for (int i = 0; i < 16; i++)
			pixelIn[i] = 12'h0a0 + 12'(i) * 12'h011;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		axiRd(`IDX_TRAINING, 32'(`RST_TRAINING), `RESP_OKAY);
		axiRd(`IDX_CHAN_DIS, 32'(`RST_CHAN_DIS), `RESP_OKAY);
		axiRd(`IDX_PIN1_SEL, 32'(`RST_PIN_SEL), `RESP_OKAY);
		axiRd(`IDX_PIN2_SEL, 32'(`RST_PIN_SEL), `RESP_OKAY);
		axiRd(`IDX_CONFIG, 32'(`RST_CONFIG), `RESP_OKAY);
		axiRd(`IDX_ROWS, 32'h800, `RESP_OKAY);
		axiRd(8'h10, 32'h0, `RESP_SLVERR);
		axiWr(`IDX_STATUS, 32'h1, `RESP_SLVERR);
		axiWr(`IDX_TRAINING, 32'hffff_f5a5, `RESP_OKAY);
		axiRd(`IDX_TRAINING, 32'h5a5, `RESP_OKAY);
		trainVal = 12'h5a5;
		axiWr(`IDX_PIN2_SEL, 32'h1, `RESP_OKAY);
		waitLock();
		setIn(1'b0, 1'b1, 1'b0);
		setIn(1'b0, 1'b0, 1'b1);
		setIn(1'b1, 1'b1, 1'b1);
		setIn(1'b0, 1'b0, 1'b0);
		axiWr(`IDX_PIN1_SEL, 32'h2, `RESP_OKAY);
		runFrame(fmt_pkg::MODE16, 1'b0, 2, 24'h0, 8'h04);
		runFrame(fmt_pkg::MODE8, 1'b0, 1, 24'h00aaaa, 8'h03);
		runFrame(fmt_pkg::MODE4, 1'b0, 1, 24'h0, 8'h03);
		runFrame(fmt_pkg::MODE2, 1'b0, 1, 24'h0, 8'h03);
		runFrame(fmt_pkg::MODE16, 1'b1, 1, 24'h0, 8'h03);
		axiRd(`IDX_STATUS, 32'h0001_8000, `RESP_OKAY);
		chk(32'(clkErr), 32'h0, "bit0 clock phase");
		testDone();
	end
endmodule
`default_nettype wire
